// ### src/adc_ctl_params.svh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices: byte address is four times the index
// ----------------------------------------------------------------------------
`define IDX_SAMPLE_CFG 8'haa
`define IDX_PIN_EN_LO 8'hab
`define IDX_PIN_EN_HI 8'hac
`define IDX_CTRL 8'had
`define IDX_RESULT_LO 8'hae
`define IDX_RESULT_HI 8'haf
`define IDX_IRQ_STATUS 8'hb0
`define IDX_IRQ_MASK 8'hb1
`define IDX_OPTION 8'hc2

// ----------------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------------
`define CTRL_POWER 7
`define CTRL_START 6
`define CTRL_FLAG 5
`define SAMPLE_CFG_LONG 3
`define OPTION_REF 7
`define IRQ_DONE 0
`define IRQ_ABORT 1
`define CHSEL_LAST_PIN 5'h09
`define CHSEL_QUARTER 5'h1f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CTRL_RESET 8'h00
`define SAMPLE_CFG_RESET 4'h0
`define PIN_EN_RESET 10'h000
`define IRQ_MASK_RESET 2'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 20
`define OSC_MHZ 24
`define CONV_TIME_NS 950
`define CONV_CYCLES ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define SAMPLE_SHORT 6
`define SAMPLE_LONG 36
`define CAPTURE_CYCLES 5
`define DIV_TABLE {6'd3, 6'd4, 6'd6, 6'd8, 6'd12, 6'd16, 6'd24, 6'd32}

`endif

// ### src/adc_ctl_pkg.sv
// types shared by the converter control files
package adc_ctl_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_CAPTURE} conv_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic power;
        logic ref_internal;
        logic sample;
        logic convert;
        logic vdd_quarter;
        logic [9:0] ain_sel;
        logic [9:0] pin_analog;
    } analog_ctrl_t;

    typedef struct packed {
        conv_state_t state;
        logic [5:0] cnt;
        logic power;
        logic flag;
        logic [4:0] chsel;
        logic long_sample;
        logic [2:0] div;
        logic [9:0] pin_en;
        logic ref_sel;
        logic opt_loaded;
        logic [11:0] result;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic ack;
        logic [7:0] rdata;
    } ctl_state_t;

endpackage

// ### src/conv_clock_divider.sv
// converter clock enable derived from the fast oscillator rate
`timescale 1ns/1ps
`include "adc_ctl_params.svh"

module conv_clock_divider (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic run,
    input wire logic [2:0] code,
    // converter clock enable
    output logic tick
);

    typedef struct packed {
        logic [9:0] acc;
        logic tick;
    } div_state_t;

    localparam logic [47:0] DIV_TABLE = `DIV_TABLE;

    div_state_t q;
    div_state_t n;
    logic [5:0] ratio;
    logic [9:0] thr;
    logic [9:0] sum;

    // ------------------------------------------------------------------------
    // fractional divider
    // ------------------------------------------------------------------------
    // the oscillator is faster than clk, so oscillator edges are accumulated:
    // each clk adds the oscillator rate, a tick fires per ratio*clk_rate units,
    // which keeps the converter rate tied to the oscillator only
    always_comb begin
        n = q;
        ratio = DIV_TABLE[{3'h0, code} * 6'd6 +: 6];
        thr = 10'(`CLK_MHZ) * {4'h0, ratio};
        sum = q.acc + 10'(`OSC_MHZ);
        n.tick = 1'b0;
        if (!run) begin
            n.acc = 10'h000;
        end else if (sum >= thr) begin
            n.acc = sum - thr;
            n.tick = 1'b1;
        end else begin
            n.acc = sum;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick = q.tick;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    tick_spacing_a: assert property (@(posedge clk) disable iff (!resetn)
        q.tick |=> !q.tick) else $error("converter clock enable ran at clk rate");
    fastest_rate_a: assert property (@(posedge clk) disable iff (!resetn)
        (run && code == 3'h7 && !q.tick) [*3] |-> ##[0:1] q.tick)
        else $error("divide by three produced no tick");

endmodule

// ### src/result_sync.sv
// three-stage synchroniser for the converter result bus
`timescale 1ns/1ps

module result_sync #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // asynchronous word and its settled copy
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] d_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] value;
    } sync_state_t;

    sync_state_t q;
    sync_state_t n;

    // ------------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------------
    // s1 feeds only s2; a word is taken once two later stages agree
    always_comb begin
        n = q;
        n.s1 = d_async;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.value = q.s3;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign d_sync = q.value;

    agree_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(q.value) |-> $past(q.s2) == $past(q.s3))
        else $error("result taken before stages agreed");

endmodule

// ### src/sar_adc_control.sv
// register interface, sequencing and analog steering of the 12-bit converter
`timescale 1ns/1ps
`include "adc_ctl_params.svh"

// Operation
// - 12-bit result, eleven selectable input channels
// - ten channels share pads with I/O
// - reference is supply or internal 2.4V
// - converter clock always from fast oscillator
// - control bit 7 powers converter
// - writing one to bit 6 starts
// - start clears flag, completion sets it
// - flag is interrupt request, software clears
// - codes 0 to 9 pick pin
// - codes 10 to 30 select nothing
// - code 31 selects quarter supply
// - sample 6 or 36 clocks, convert 950ns
// - divider code picks /32 down to /3
// - analog enable takes pin, drops pull-up
// - reference option loaded from strap default
module sar_adc_control (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // wishbone slave
    input wire adc_ctl_pkg::wb_req_t wb_i,
    output adc_ctl_pkg::wb_rsp_t wb_o,
    // analog macro
    output adc_ctl_pkg::analog_ctrl_t ana_o,
    input wire logic [11:0] conv_result_raw,
    // option strap and interrupts
    input wire logic ref_option_strap,
    output logic converter_irq_flag,
    output logic irq
);

    localparam logic [7:0] CTRL_RST = `CTRL_RESET;
    localparam logic [3:0] CFG_RST = `SAMPLE_CFG_RESET;
    localparam adc_ctl_pkg::ctl_state_t Q_RESET = '{
        state: adc_ctl_pkg::ST_IDLE,
        cnt: 6'h00,
        power: CTRL_RST[`CTRL_POWER],
        flag: CTRL_RST[`CTRL_FLAG],
        chsel: CTRL_RST[4:0],
        long_sample: CFG_RST[`SAMPLE_CFG_LONG],
        div: CFG_RST[2:0],
        pin_en: `PIN_EN_RESET,
        ref_sel: 1'b0,
        opt_loaded: 1'b0,
        result: 12'h000,
        irq_status: 2'h0,
        irq_mask: `IRQ_MASK_RESET,
        ack: 1'b0,
        rdata: 8'h00
    };
    localparam logic [5:0] CONV_LAST = 6'(`CONV_CYCLES - 1);
    localparam logic [5:0] CAP_LAST = 6'(`CAPTURE_CYCLES - 1);
    localparam logic [5:0] SHORT_LAST = 6'(`SAMPLE_SHORT - 1);
    localparam logic [5:0] LONG_LAST = 6'(`SAMPLE_LONG - 1);

    adc_ctl_pkg::ctl_state_t q;
    adc_ctl_pkg::ctl_state_t n;
    logic hit;
    logic wr;
    logic wr_ctrl;
    logic rd_ctrl;
    logic start;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [5:0] sample_last;
    logic tick;
    logic [11:0] sync_result;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    conv_clock_divider u_div (
        .clk(clk),
        .resetn(resetn),
        .run(q.state == adc_ctl_pkg::ST_SAMPLE),
        .code(q.div),
        .tick(tick)
    );

    result_sync #(.W(12)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d_async(conv_result_raw),
        .d_sync(sync_result)
    );

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    // one wait state: ack rises the cycle after the strobe and drops after one
    always_comb begin
        hit = wb_i.cyc && wb_i.stb && !q.ack;
        idx = wb_i.adr[9:2];
        wd = wb_i.dat[7:0];
        wr = hit && wb_i.we && wb_i.sel[0];
        wr_ctrl = wr && (idx == `IDX_CTRL);
        rd_ctrl = hit && !wb_i.we && (idx == `IDX_CTRL);
        // a start with the power bit low in the same write is dropped
        start = wr_ctrl && wd[`CTRL_START] && wd[`CTRL_POWER];
        sample_last = q.long_sample ? LONG_LAST : SHORT_LAST;
        unique case (idx)
            `IDX_CTRL: rd = {q.power, 1'b0, q.flag, q.chsel};
            `IDX_SAMPLE_CFG: rd = {4'h0, q.long_sample, q.div};
            `IDX_PIN_EN_LO: rd = q.pin_en[7:0];
            `IDX_PIN_EN_HI: rd = {6'h00, q.pin_en[9:8]};
            `IDX_RESULT_LO: rd = q.result[7:0];
            `IDX_RESULT_HI: rd = {4'h0, q.result[11:8]};
            `IDX_IRQ_STATUS: rd = {6'h00, q.irq_status};
            `IDX_IRQ_MASK: rd = {6'h00, q.irq_mask};
            `IDX_OPTION: rd = {q.ref_sel, 7'h00};
            default: rd = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // registers and sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        n = q;
        n.ack = hit;
        if (hit) begin
            n.rdata = rd;
        end
        // reference default is caught once, after reset release
        if (!q.opt_loaded) begin
            n.opt_loaded = 1'b1;
            n.ref_sel = ref_option_strap;
        end
        if (wr) begin
            unique case (idx)
                `IDX_CTRL: begin
                    n.power = wd[`CTRL_POWER];
                    n.flag = wd[`CTRL_FLAG];
                    n.chsel = wd[4:0];
                end
                `IDX_SAMPLE_CFG: begin
                    n.long_sample = wd[`SAMPLE_CFG_LONG];
                    n.div = wd[2:0];
                end
                `IDX_PIN_EN_LO: n.pin_en[7:0] = wd;
                `IDX_PIN_EN_HI: n.pin_en[9:8] = wd[1:0];
                `IDX_IRQ_STATUS: n.irq_status = q.irq_status & ~wd[1:0];
                `IDX_IRQ_MASK: n.irq_mask = wd[1:0];
                `IDX_OPTION: n.ref_sel = wd[`OPTION_REF];
                default: n.rdata = n.rdata;
            endcase
        end
        // losing power mid-conversion discards it and raises the abort status; the flag takes bit 5 of that write
        if (!n.power && q.state != adc_ctl_pkg::ST_IDLE) begin
            n.state = adc_ctl_pkg::ST_IDLE;
            n.cnt = 6'h00;
            n.irq_status[`IRQ_ABORT] = 1'b1;
        end else begin
            unique case (q.state)
                adc_ctl_pkg::ST_IDLE: begin
                    // a start during a conversion is not taken
                    if (start) begin
                        n.state = adc_ctl_pkg::ST_SAMPLE;
                        n.cnt = 6'h00;
                        n.flag = 1'b0;
                    end
                end
                adc_ctl_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (q.cnt == sample_last) begin
                            n.state = adc_ctl_pkg::ST_CONVERT;
                            n.cnt = 6'h00;
                        end else begin
                            n.cnt = q.cnt + 6'h01;
                        end
                    end
                end
                adc_ctl_pkg::ST_CONVERT: begin
                    if (q.cnt == CONV_LAST) begin
                        n.state = adc_ctl_pkg::ST_CAPTURE;
                        n.cnt = 6'h00;
                    end else begin
                        n.cnt = q.cnt + 6'h01;
                    end
                end
                adc_ctl_pkg::ST_CAPTURE: begin
                    // waits for the synchroniser to settle on the final word
                    if (q.cnt == CAP_LAST) begin
                        n.state = adc_ctl_pkg::ST_IDLE;
                        n.cnt = 6'h00;
                        n.result = sync_result;
                        n.flag = 1'b1;
                        n.irq_status[`IRQ_DONE] = 1'b1;
                    end else begin
                        n.cnt = q.cnt + 6'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= Q_RESET;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign wb_o.ack = q.ack;
    assign wb_o.dat = {24'h000000, q.rdata};
    assign converter_irq_flag = q.flag;
    assign irq = |(q.irq_status & q.irq_mask);
    assign ana_o.power = q.power;
    assign ana_o.ref_internal = q.ref_sel;
    assign ana_o.sample = q.state == adc_ctl_pkg::ST_SAMPLE;
    assign ana_o.convert = q.state == adc_ctl_pkg::ST_CONVERT;
    // reserved codes match neither term, so no input is routed
    assign ana_o.vdd_quarter = q.chsel == `CHSEL_QUARTER;
    assign ana_o.pin_analog = q.pin_en;

    genvar g;
    generate
        for (g = 0; g < 10; g++) begin : g_pin
            assign ana_o.ain_sel[g] = q.chsel == 5'(g);
        end
    endgenerate

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    trig_when_off_a: assert property (wr_ctrl && !wd[`CTRL_POWER] |=>
        q.state == adc_ctl_pkg::ST_IDLE) else $error("start taken while off");
    start_clears_a: assert property (start && q.state == adc_ctl_pkg::ST_IDLE |=>
        q.state == adc_ctl_pkg::ST_SAMPLE && !q.flag)
        else $error("start did not clear flag");
    start_reads_zero_a: assert property ($past(rd_ctrl) |-> q.ack && !q.rdata[6])
        else $error("start bit read back high");
    done_sets_flag_a: assert property ($past(q.state) == adc_ctl_pkg::ST_CAPTURE &&
        q.state == adc_ctl_pkg::ST_IDLE && q.power |->
        q.flag && q.result == $past(sync_result))
        else $error("completion missed flag or result");
    flag_sticky_a: assert property (q.flag && !wr_ctrl |=> q.flag)
        else $error("flag dropped without software");
    conv_time_a: assert property ($rose(q.state == adc_ctl_pkg::ST_CONVERT) |->
        ##18 (q.state == adc_ctl_pkg::ST_CONVERT || !q.power) ##1
        (q.state != adc_ctl_pkg::ST_CONVERT)) else $error("convert phase length");
    sample_end_a: assert property (q.state == adc_ctl_pkg::ST_SAMPLE && tick &&
        q.cnt == sample_last && !wr_ctrl |=> q.state == adc_ctl_pkg::ST_CONVERT)
        else $error("sample phase did not end");
    channel_map_a: assert property (q.chsel <= `CHSEL_LAST_PIN |->
        ana_o.ain_sel == (10'h001 << q.chsel) && !ana_o.vdd_quarter)
        else $error("pin channel misrouted");
    reserved_a: assert property (q.chsel > `CHSEL_LAST_PIN && q.chsel != `CHSEL_QUARTER
        |-> ana_o.ain_sel == 10'h000 && !ana_o.vdd_quarter)
        else $error("reserved code routed");
    quarter_a: assert property (q.chsel == `CHSEL_QUARTER |->
        ana_o.vdd_quarter && ana_o.ain_sel == 10'h000)
        else $error("quarter supply not routed");
    pin_enable_a: assert property ($past(wr && idx == `IDX_PIN_EN_LO) |->
        ana_o.pin_analog[7:0] == $past(wd)) else $error("pin enable not applied");
    ref_strap_a: assert property (q.opt_loaded && !$past(q.opt_loaded) |->
        q.ref_sel == $past(ref_option_strap)) else $error("strap not loaded");

    long_done_c: cover property (q.long_sample && q.state == adc_ctl_pkg::ST_CAPTURE
        ##1 q.state == adc_ctl_pkg::ST_IDLE && q.flag);
    abort_c: cover property ($rose(q.irq_status[`IRQ_ABORT]));
    quarter_done_c: cover property (q.chsel == `CHSEL_QUARTER && $rose(q.flag));

endmodule

// ### verification/analog_macro_model.sv
// behavioural analog macro: routes the selected input and answers on the result bus
`timescale 1ns/1ps

module analog_macro_model (
    // clock
    input wire logic clk,
    // controls from the block
    input wire adc_ctl_pkg::analog_ctrl_t ana_i,
    // result bus back to the block
    output logic [11:0] result_raw
);
    logic converting_q = 1'b0;
    logic [11:0] level;

    // each pin gives its own level so a wrong route shows up in the result
    always_comb begin
        level = 12'h000;
        for (int i = 0; i < 10; i++) begin
            if (ana_i.ain_sel[i]) begin
                level = 12'h100 | 12'(i);
            end
        end
        if (ana_i.vdd_quarter) begin
            level = 12'h3ff;
        end
    end

    initial result_raw = 12'h000;

    // the bus toggles while unsettled and holds the answer once the convert phase ends
    always @(posedge clk or negedge ana_i.convert) begin
        if (!ana_i.convert && converting_q && ana_i.power) begin
            result_raw <= level;
            converting_q <= 1'b0;
        end else if (ana_i.convert || !ana_i.power) begin
            result_raw <= ~result_raw;
            converting_q <= ana_i.convert;
        end
    end
endmodule

// ### verification/tb_sar_adc_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctl_params.svh"

module tb_sar_adc_control;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b1;
    adc_ctl_pkg::wb_req_t wb_q = '0;
    adc_ctl_pkg::wb_rsp_t wb_o;
    adc_ctl_pkg::analog_ctrl_t ana_o;
    logic [11:0] raw;
    logic irq_flag;
    logic irq;
    logic [7:0] rd;
    int mismatches = 0;
    int tests_run = 0;
    int ratio [8] = '{32, 24, 16, 12, 8, 6, 4, 3};

    always #25 clk = ~clk;

    sar_adc_control dut_u (.clk(clk), .resetn(resetn), .wb_i(wb_q), .wb_o(wb_o),
        .ana_o(ana_o), .conv_result_raw(raw), .ref_option_strap(strap),
        .converter_irq_flag(irq_flag), .irq(irq));
    analog_macro_model model_u (.clk(clk), .ana_i(ana_o), .result_raw(raw));

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; ack is read before the edge's own updates land
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hf, dat: {24'h0, wd}};
        do begin
            @(posedge clk);
            n++;
        end while (wb_o.ack !== 1'b1);
        rd = wb_o.dat[7:0];
        // one wait state: ack is seen at the second edge after the request
        check("bus latency", 32'd2, n);
        wb_q.cyc <= 1'b0;
        wb_q.stb <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        check(what, {24'h0, exp}, {24'h0, rd});
    endtask

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic reset_values();
        settle();
        rd_chk("control reset", `IDX_CTRL, `CTRL_RESET);
        rd_chk("option strap", `IDX_OPTION, 8'h80);
        rd_chk("unmapped read", 8'h00, 8'h00);
        check("reference internal", 32'h1, ana_o.ref_internal);
        check("power idle", 32'h0, ana_o.power);
        check("irq idle", 32'h0, irq);
    endtask

    task automatic routing();
        for (int c = 0; c < 32; c++) begin
            xfer(1'b1, `IDX_CTRL, c[7:0]);
            settle();
            check("pin route", (c <= 9) ? (32'h1 << c) : 32'h0, ana_o.ain_sel);
            check("quarter supply", c == 31, ana_o.vdd_quarter);
        end
        xfer(1'b1, `IDX_CTRL, 8'h43);
        repeat (3) settle();
        check("start while off", 32'h0, ana_o.sample);
        rd_chk("trigger reads zero", `IDX_CTRL, 8'h03);
        xfer(1'b1, `IDX_CTRL, 8'h80);
        settle();
        check("power on", 32'h1, ana_o.power);
        xfer(1'b1, `IDX_PIN_EN_LO, 8'h5a);
        xfer(1'b1, `IDX_PIN_EN_HI, 8'h02);
        xfer(1'b1, `IDX_OPTION, 8'h00);
        settle();
        check("pin analog", 32'h25a, ana_o.pin_analog);
        check("reference supply", 32'h0, ana_o.ref_internal);
    endtask

    task automatic run_conv(input logic [2:0] div, input logic lng, input logic [4:0] ch,
        input logic msk);
        int s;
        int v;
        int n;
        int exp_s;
        logic [11:0] lvl;
        s = 0;
        v = 0;
        n = 0;
        exp_s = (lng ? 30 : 5) * ratio[div];
        lvl = (ch == 5'h1f) ? 12'h3ff : (ch <= 5'h09) ? (12'h100 | 12'(ch)) : 12'h000;
        xfer(1'b1, `IDX_IRQ_MASK, {7'h0, msk});
        xfer(1'b1, `IDX_SAMPLE_CFG, {4'h0, lng, div});
        xfer(1'b1, `IDX_CTRL, {3'b110, ch});
        // control is left alone until the flag is up
        do begin
            settle();
            s += int'(ana_o.sample);
            v += int'(ana_o.convert);
            n++;
        end while (irq_flag !== 1'b1 && n < 1500);
        check("sample length", 32'h1, {31'h0, s >= exp_s - 3 && s <= exp_s + 3});
        check("convert length", `CONV_CYCLES, v);
        check("done flag", 32'h1, irq_flag);
        check("irq level", {31'h0, msk}, irq);
        rd_chk("control done", `IDX_CTRL, {3'b101, ch});
        rd_chk("result low", `IDX_RESULT_LO, lvl[7:0]);
        rd_chk("result high", `IDX_RESULT_HI, {4'h0, lvl[11:8]});
        xfer(1'b1, `IDX_CTRL, {3'b100, ch});
        repeat (4) settle();
        check("flag cleared", 32'h0, irq_flag);
        check("no restart", 32'h0, ana_o.sample);
        xfer(1'b1, `IDX_IRQ_MASK, 8'h01);
        settle();
        check("irq sticky", 32'h1, irq);
        xfer(1'b1, `IDX_IRQ_STATUS, 8'h01);
        settle();
        check("irq cleared", 32'h0, irq);
    endtask

    // second reset in mid-run with the strap low: registers and reference default reload
    task automatic reset_again();
        @(posedge clk);
        strap <= 1'b0;
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        settle();
        check("reset power", 32'h0, ana_o.power);
        check("reset pin analog", 32'h0, ana_o.pin_analog);
        check("reset reference", 32'h0, ana_o.ref_internal);
        rd_chk("control after reset", `IDX_CTRL, `CTRL_RESET);
        rd_chk("option strap low", `IDX_OPTION, 8'h00);
    endtask

    // ------------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        reset_values();
        routing();
        for (int d = 0; d < 8; d++) begin
            run_conv(d[2:0], 1'b0, 5'(d + 2), 1'b1);
        end
        run_conv(3'h7, 1'b1, 5'h1f, 1'b0);
        run_conv(3'h0, 1'b1, 5'h0c, 1'b1);
        reset_again();
        complete_run();
    end

    // the whole run needs a few thousand cycles; ten thousand means a hang
    initial begin
        #(10000 * 50);
        mismatches++;
        complete_run();
    end
endmodule
